// ---- rtl/hscr_regs.sv ----
`timescale 1ns/100ps
// Overview of operation
// - The capability register reports a fixed isochronous threshold in bits 7 to 4.
// - With the threshold top bit clear, the low three bits give the hold time in microframes.
// - Without a programmable list, the frame list size field is read-only and reads zero.
// - With a programmable list, software may write a smaller frame list size.
// - Capability bit 0 reports 32-bit (0) or 64-bit (1) data structure pointers.
// - The command register answers at offset 0Ch.
// - A write to the command register makes the controller act on the written fields.
// - The interrupt threshold defaults to eight microframes and caps the interrupt rate.
// - Light reset reads one while in progress and zero when done or not implemented.
module hscr_regs
    import hscr_pkg::*;
#(
    parameter logic [ISO_THR_W-1:0] ISO_THRESHOLD = ISO_THR_DEFAULT,
    parameter bit PROG_LIST = 1'b1,
    parameter bit WIDE_PTR = 1'b0,
    parameter bit LIGHT_RST_IMPL = 1'b1
) (
    input wire logic clk_sys_in, // 40 MHz clock
    input wire logic rst_in, // Async reset, high
    input wire logic ce_in, // Clock enable
    input wire logic [hscr_pkg::ADDR_W-1:0] addr_in, // Byte offset
    input wire logic wr_in, // Write strobe
    input wire logic rd_in, // Read strobe
    input wire logic [hscr_pkg::DATA_W-1:0] wdata_in, // Write data
    input wire logic crst_done_in, // Controller reset finished
    input wire logic lrst_done_in, // Light reset finished
    input wire logic dbell_ack_in, // Doorbell serviced
    output logic [hscr_pkg::DATA_W-1:0] rdata_out, // Read data
    output hscr_pkg::hscr_cmd_s cmd_out, // Command fields
    output logic cmd_wr_out // Command written pulse
);
    import hscr_pkg::*;

    hscr_cmd_s cmd_q;
    hscr_cmd_s cmd_d;
    logic cmd_wr_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] cap_word;
    logic [DATA_W-1:0] cmd_word;
    logic cmd_hit;

    assign cmd_hit = wr_in && (addr_in == HOST_CMD_OFS);

    always_comb begin
        cap_word = ZERO_WORD;
        cap_word[ISO_THR_LSB +: ISO_THR_W] = ISO_THRESHOLD;
        cap_word[PLF_BIT] = PROG_LIST;
        cap_word[WIDE_BIT] = WIDE_PTR;
    end

    always_comb begin
        cmd_word = ZERO_WORD;
        cmd_word[RUN_BIT] = cmd_q.run_stop;
        cmd_word[CRST_BIT] = cmd_q.controller_reset;
        cmd_word[LIST_SIZE_LSB +: LIST_SIZE_W] = cmd_q.frame_list_size;
        cmd_word[PERIODIC_BIT] = cmd_q.periodic_schedule_enable;
        cmd_word[ASYNC_BIT] = cmd_q.async_schedule_enable;
        cmd_word[DBELL_BIT] = cmd_q.async_advance_doorbell;
        cmd_word[LRST_BIT] = cmd_q.light_controller_reset;
        cmd_word[INT_THR_LSB +: INT_THR_W] = cmd_q.interrupt_threshold;
    end

    always_comb begin
        cmd_d = cmd_q;
        // Self-clearing bits drop when the controller reports done
        if (crst_done_in) begin
            cmd_d.controller_reset = 1'b0;
        end
        if (lrst_done_in) begin
            cmd_d.light_controller_reset = 1'b0;
        end
        if (dbell_ack_in) begin
            cmd_d.async_advance_doorbell = 1'b0;
        end
        if (cmd_hit) begin
            cmd_d.run_stop = wdata_in[RUN_BIT];
            cmd_d.periodic_schedule_enable = wdata_in[PERIODIC_BIT];
            cmd_d.async_schedule_enable = wdata_in[ASYNC_BIT];
            cmd_d.interrupt_threshold = wdata_in[INT_THR_LSB +: INT_THR_W];
            // Writing one sets, set wins over a same-cycle done
            cmd_d.controller_reset = cmd_d.controller_reset | wdata_in[CRST_BIT];
            cmd_d.async_advance_doorbell = cmd_d.async_advance_doorbell
                | wdata_in[DBELL_BIT];
            if (LIGHT_RST_IMPL) begin
                cmd_d.light_controller_reset = cmd_d.light_controller_reset
                    | wdata_in[LRST_BIT];
            end
            if (PROG_LIST) begin
                cmd_d.frame_list_size = wdata_in[LIST_SIZE_LSB +: LIST_SIZE_W];
            end
        end
        if (!PROG_LIST) begin
            cmd_d.frame_list_size = LIST_SIZE_RESET;
        end
        if (!LIGHT_RST_IMPL) begin
            cmd_d.light_controller_reset = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_q <= CMD_RESET;
        end else if (ce_in) begin
            cmd_q <= cmd_d;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cmd_wr_q <= 1'b0;
        end else if (ce_in) begin
            cmd_wr_q <= cmd_hit;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= ZERO_WORD;
        end else if (ce_in && rd_in) begin
            case (addr_in)
                CAP_PARAMS_OFS: begin
                    rdata_q <= cap_word;
                end
                HOST_CMD_OFS: begin
                    rdata_q <= cmd_word;
                end
                default: begin
                    rdata_q <= ZERO_WORD;
                end
            endcase
        end
    end

    assign rdata_out = rdata_q;
    assign cmd_out = cmd_q;
    assign cmd_wr_out = cmd_wr_q;

    property p_cap_read;
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && rd_in && addr_in == CAP_PARAMS_OFS) |=>
            rdata_out[7:4] == ISO_THRESHOLD && rdata_out[31:8] == 24'h000000
            && rdata_out[3:2] == 2'h0;
    endproperty
    a_cap_read: assert property (p_cap_read) else $error("capability read wrong");

    property p_iso_low_bits;
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && rd_in && addr_in == CAP_PARAMS_OFS && !ISO_THRESHOLD[3]) |=>
            rdata_out[6:4] == ISO_THRESHOLD[2:0] && !rdata_out[7];
    endproperty
    a_iso_low_bits: assert property (p_iso_low_bits) else $error("threshold bits wrong");

    property p_wide_ptr;
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && rd_in && addr_in == CAP_PARAMS_OFS) |=>
            rdata_out[0] == WIDE_PTR && rdata_out[1] == PROG_LIST;
    endproperty
    a_wide_ptr: assert property (p_wide_ptr) else $error("pointer width bit wrong");

    property p_fls_fixed;
        @(posedge clk_sys_in) disable iff (rst_in)
        !PROG_LIST |-> cmd_out.frame_list_size == 2'h0;
    endproperty
    a_fls_fixed: assert property (p_fls_fixed) else $error("list size not zero");

    property p_fls_write;
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && cmd_hit && PROG_LIST) |=>
            cmd_out.frame_list_size == $past(wdata_in[3:2]);
    endproperty
    a_fls_write: assert property (p_fls_write) else $error("list size not taken");

    property p_cmd_write;
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && cmd_hit) |=> cmd_wr_out && cmd_out.run_stop == $past(wdata_in[0])
            && cmd_out.interrupt_threshold == $past(wdata_in[23:16]);
    endproperty
    a_cmd_write: assert property (p_cmd_write) else $error("command write lost");

    property p_cmd_read;
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && rd_in && addr_in == HOST_CMD_OFS) |=>
            rdata_out[31:24] == 8'h00 && rdata_out[15:8] == 8'h00
            && rdata_out[23:16] == $past(cmd_out.interrupt_threshold);
    endproperty
    a_cmd_read: assert property (p_cmd_read) else $error("command readback wrong");

    property p_reset_value;
        @(posedge clk_sys_in)
        $fell(rst_in) |-> cmd_out == CMD_RESET;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("reset value wrong");

    property p_light_rst;
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && cmd_out.light_controller_reset && !lrst_done_in) |=>
            cmd_out.light_controller_reset;
    endproperty
    a_light_rst: assert property (p_light_rst) else $error("light reset dropped early");

    property p_light_absent;
        @(posedge clk_sys_in) disable iff (rst_in)
        !LIGHT_RST_IMPL |-> !cmd_out.light_controller_reset;
    endproperty
    a_light_absent: assert property (p_light_absent) else $error("light reset set");

    property p_set_wins;
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && cmd_hit && wdata_in[CRST_BIT] && wdata_in[DBELL_BIT]) |=>
            cmd_out.controller_reset && cmd_out.async_advance_doorbell;
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("self-clearing set lost");

    property p_wr_pulse;
        @(posedge clk_sys_in) disable iff (rst_in)
        (ce_in && !cmd_hit) |=> !cmd_wr_out;
    endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too long");
endmodule : hscr_regs

// ---- rtl/hscr_pkg.sv ----
package hscr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] CAP_PARAMS_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] HOST_CMD_OFS = 8'h0C;
    // Capability field positions
    localparam int ISO_THR_LSB = 4;
    localparam int ISO_THR_W = 4;
    localparam int PLF_BIT = 1;
    localparam int WIDE_BIT = 0;
    // Command field positions
    localparam int RUN_BIT = 0;
    localparam int CRST_BIT = 1;
    localparam int LIST_SIZE_LSB = 2;
    localparam int LIST_SIZE_W = 2;
    localparam int PERIODIC_BIT = 4;
    localparam int ASYNC_BIT = 5;
    localparam int DBELL_BIT = 6;
    localparam int LRST_BIT = 7;
    localparam int INT_THR_LSB = 16;
    localparam int INT_THR_W = 8;
    localparam logic [INT_THR_W-1:0] INT_THR_RESET = 8'h08;
    localparam logic [LIST_SIZE_W-1:0] LIST_SIZE_RESET = 2'h0;
    localparam logic [ISO_THR_W-1:0] ISO_THR_DEFAULT = 4'h1;
    localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

    typedef struct packed {
        logic [INT_THR_W-1:0] interrupt_threshold;
        logic light_controller_reset;
        logic async_advance_doorbell;
        logic async_schedule_enable;
        logic periodic_schedule_enable;
        logic [LIST_SIZE_W-1:0] frame_list_size;
        logic controller_reset;
        logic run_stop;
    } hscr_cmd_s;

    localparam hscr_cmd_s CMD_RESET = '{
        interrupt_threshold: INT_THR_RESET,
        frame_list_size: LIST_SIZE_RESET,
        default: 1'b0
    };
endpackage : hscr_pkg

// ---- verif/hs_host_capability_command_regs_tb_top.sv ----
`timescale 1ns/100ps
module hs_host_capability_command_regs_tb_top;
    import hscr_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce_in = 1'b1;
    logic [ADDR_W-1:0] addr_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [DATA_W-1:0] wdata_in = 32'h0000_0000;
    logic crst_done_in = 1'b0;
    logic lrst_done_in = 1'b0;
    logic dbell_ack_in = 1'b0;
    logic [DATA_W-1:0] rdata_out;
    hscr_cmd_s cmd_out;
    logic cmd_wr_out;
    logic [DATA_W-1:0] rdata_fix;
    hscr_cmd_s cmd_fix;
    logic cmd_wr_fix;
    int error_cnt = 0;
    int n_compared = 0;

    hscr_regs uut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in),
        .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in), .crst_done_in(crst_done_in),
        .lrst_done_in(lrst_done_in), .dbell_ack_in(dbell_ack_in), .rdata_out(rdata_out),
        .cmd_out(cmd_out), .cmd_wr_out(cmd_wr_out));

    // Fixed list, no light reset, wide pointers, whole-frame threshold
    hscr_regs #(.ISO_THRESHOLD(4'h8), .PROG_LIST(1'b0), .WIDE_PTR(1'b1),
        .LIGHT_RST_IMPL(1'b0)) uut_fix (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .ce_in(ce_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in),
        .crst_done_in(crst_done_in), .lrst_done_in(lrst_done_in),
        .dbell_ack_in(dbell_ack_in), .rdata_out(rdata_fix), .cmd_out(cmd_fix),
        .cmd_wr_out(cmd_wr_fix));

    always #12.5 clk_sys_in = ~clk_sys_in;

    task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_sys_in);
        wr_in <= 1'b0;
        #1;
    endtask : reg_wr

    task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk_sys_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_sys_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp);
    endtask : reg_rd

    task automatic test_reset_values;
        chk({16'h0000, cmd_out}, 32'h0000_0800);
        reg_rd(CAP_PARAMS_OFS, 32'h0000_0012);
        reg_rd(HOST_CMD_OFS, 32'h0008_0000);
        $display("test_reset_values done");
    endtask : test_reset_values

    task automatic test_cmd_write;
        reg_wr(HOST_CMD_OFS, 32'hFF10_FF3D);
        chk({31'h0, cmd_wr_out}, 32'h1);
        chk({16'h0000, cmd_out}, 32'h0000_103D);
        @(posedge clk_sys_in);
        #1;
        chk({31'h0, cmd_wr_out}, 32'h0);
        reg_rd(HOST_CMD_OFS, 32'h0010_003D);
        reg_rd(CAP_PARAMS_OFS, 32'h0000_0012);
        $display("test_cmd_write done");
    endtask : test_cmd_write

    task automatic test_self_clearing;
        // Stop first so the threshold only changes while halted
        reg_wr(HOST_CMD_OFS, 32'h0010_0000);
        reg_wr(HOST_CMD_OFS, 32'h0008_00C2);
        reg_rd(HOST_CMD_OFS, 32'h0008_00C2);
        @(posedge clk_sys_in);
        lrst_done_in <= 1'b1;
        @(posedge clk_sys_in);
        lrst_done_in <= 1'b0;
        reg_rd(HOST_CMD_OFS, 32'h0008_0042);
        @(posedge clk_sys_in);
        crst_done_in <= 1'b1;
        dbell_ack_in <= 1'b1;
        @(posedge clk_sys_in);
        crst_done_in <= 1'b0;
        dbell_ack_in <= 1'b0;
        reg_rd(HOST_CMD_OFS, 32'h0008_0000);
        $display("test_self_clearing done");
    endtask : test_self_clearing

    task automatic test_unmapped_and_ce;
        reg_wr(8'h10, 32'h0040_0001);
        chk({31'h0, cmd_wr_out}, 32'h0);
        reg_wr(CAP_PARAMS_OFS, 32'hFFFF_FFFF);
        reg_rd(8'h10, 32'h0000_0000);
        reg_rd(CAP_PARAMS_OFS, 32'h0000_0012);
        @(posedge clk_sys_in);
        ce_in <= 1'b0;
        reg_wr(HOST_CMD_OFS, 32'h0001_0031);
        chk({31'h0, cmd_wr_out}, 32'h0);
        @(posedge clk_sys_in);
        ce_in <= 1'b1;
        reg_rd(HOST_CMD_OFS, 32'h0008_0000);
        $display("test_unmapped_and_ce done");
    endtask : test_unmapped_and_ce

    task automatic test_fixed_variant;
        reg_wr(HOST_CMD_OFS, 32'h0008_008C);
        chk({31'h0, cmd_wr_fix}, 32'h1);
        chk({16'h0000, cmd_fix}, 32'h0000_0800);
        reg_rd(HOST_CMD_OFS, 32'h0008_008C);
        chk(rdata_fix, 32'h0008_0000);
        reg_rd(CAP_PARAMS_OFS, 32'h0000_0012);
        chk({31'h0, rdata_fix[1]}, 32'h0);
        chk({28'h0, rdata_fix[7:4]}, 32'h8);
        chk(rdata_fix, 32'h0000_0081);
        $display("test_fixed_variant done");
    endtask : test_fixed_variant

    task automatic tally_and_finish;
        $display("compared=%0d mismatches=%0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        #100000;
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        test_reset_values();
        test_cmd_write();
        test_self_clearing();
        test_unmapped_and_ce();
        test_fixed_variant();
        tally_and_finish();
    end
endmodule : hs_host_capability_command_regs_tb_top
